// File: common/flash_seq_consts.svh
// Constants for the flash self-programming sequencer
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH
`define CMD_BLANK_CHECK   8'h04
`define CMD_BYTE_WRITE    8'h05
`define WDT_RESTART_CODE  8'hac
`define STAT_VERIFY_BIT   1
`define STAT_PROTECT_BIT  2
`define STAT_RESET        8'h00
`define BLANK_BYTE        8'hff
`define LAST_BLOCK        8'h07
`define CLK_PERIOD_NS     100
`define PROG_TIME_NS      1000
`define PROG_CYCLES       ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: common/flash_seq_pkg.sv
// Types for the flash self-programming sequencer
package flash_seq_pkg;
  typedef enum logic [1:0] {S_IDLE, S_BLANK, S_PROG, S_VERIFY} seq_state_e;
  typedef struct packed {
    seq_state_e st;
    logic [7:0] blk;
    logic [7:0] lo;
    logic [7:0] end_lo;
    logic [7:0] data;
    logic [7:0] cnt;
    logic       busy;
    logic       done;
    logic       err;
    logic       wr_en;
    logic       wdt;
    logic [7:0] stat;
  } seq_s;
endpackage

// File: core/flash_self_prog_blank_check_write.sv
// Flash self-programming sequencer: blank check and byte write
// Operation
// (R01) Command 04H runs a block blank check
// (R02) Software loads block number in pointer high
// (R03) Software sets low pointer 00H, compare FFH
// (R04) Compare high equals pointer high for check
// (R05) Software clears status before each command
// (R06) Writing ACH to watchdog restarts its counter
// (R07) HALT launches command, CPU resumes after
// (R08) Bit 1 verify error, bit 2 protect error
// (R09) Command 05H programs one flash byte
// (R10) Software loads block and byte address pointers
// (R11) Sequencer programs exactly the buffered byte
// (R12) On write failure, erase block then rewrite; the sequencer only sets the verify error bit and finishes
// (R13) Status zero on success, nonzero on failure
// (R14) Error bits stay set until software clears
`timescale 1ns/100ps
`include "flash_seq_consts.svh"

module flash_self_prog_blank_check_write
  import flash_seq_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        self_prog_mode,
  input  wire logic        halt_exec,
  input  wire logic [7:0]  flash_command_reg,
  input  wire logic [7:0]  addr_pointer_high,
  input  wire logic [7:0]  addr_pointer_low,
  input  wire logic [7:0]  addr_compare_high,
  input  wire logic [7:0]  addr_compare_low,
  input  wire logic [7:0]  write_data_buffer,
  input  wire logic        status_wr,
  input  wire logic [7:0]  status_wdata,
  input  wire logic        wdt_wr,
  input  wire logic [7:0]  wdt_wdata,
  input  wire logic [7:0]  flash_rd_data,
  output logic             cpu_halted,
  output logic             op_done,
  output logic [7:0]       flash_status_reg,
  output logic [15:0]      flash_addr,
  output logic             flash_wr_en,
  output logic [7:0]       flash_wr_data,
  output logic             wdt_restart
);

  localparam logic [7:0] PROG_LAST = 8'(`PROG_CYCLES - 1);

  seq_s q;
  seq_s d;

  logic start;
  logic blank_cmd;
  logic write_cmd;
  logic blank_ok;
  logic write_ok;
  logic set_verify;
  logic set_protect;

  assign start     = halt_exec && self_prog_mode && (q.st == S_IDLE);
  assign blank_cmd = flash_command_reg == `CMD_BLANK_CHECK;
  assign write_cmd = flash_command_reg == `CMD_BYTE_WRITE;
  // A range that leaves the block or runs backwards is a protection fault
  assign blank_ok  = (addr_pointer_high <= `LAST_BLOCK)
                  && (addr_compare_high == addr_pointer_high)
                  && (addr_pointer_low <= addr_compare_low);
  assign write_ok  = addr_pointer_high <= `LAST_BLOCK;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    d           = q;
    d.done      = 1'b0;
    d.wdt       = wdt_wr && (wdt_wdata == `WDT_RESTART_CODE); // see (R06)
    set_verify  = 1'b0;
    set_protect = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        if (start) begin
          d.busy   = 1'b1; // see (R07)
          d.blk    = addr_pointer_high;
          d.lo     = addr_pointer_low;
          d.end_lo = addr_compare_low;
          d.data   = write_data_buffer;
          d.err    = 1'b0;
          if (blank_cmd && blank_ok) begin
            d.st = S_BLANK; // see (R01)
          end else if (write_cmd && write_ok) begin
            d.st    = S_PROG; // see (R09)
            d.wr_en = 1'b1;
            d.cnt   = PROG_LAST;
          end else begin
            // Unknown command or bad range: finish at once, flagged
            set_protect = 1'b1;
            d.err       = 1'b1;
            d.busy      = 1'b0;
            d.done      = 1'b1;
          end
        end
      end
      S_BLANK: begin
        if (flash_rd_data != `BLANK_BYTE) begin
          set_verify = 1'b1; // see (R08)
          d.err      = 1'b1;
        end
        if (q.lo == q.end_lo) begin
          d.st   = S_IDLE;
          d.busy = 1'b0; // see (R07)
          d.done = 1'b1;
        end else begin
          d.lo = q.lo + 8'h01;
        end
      end
      S_PROG: begin
        if (q.cnt == 8'h00) begin
          d.wr_en = 1'b0;
          d.st    = S_VERIFY;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      S_VERIFY: begin
        // Read back so a weak cell is reported, not silently kept
        if (flash_rd_data != q.data) begin
          set_verify = 1'b1; // see (R08)
          d.err      = 1'b1;
        end
        d.st   = S_IDLE;
        d.busy = 1'b0; // see (R07)
        d.done = 1'b1;
      end
    endcase
    if (status_wr) begin
      d.stat = status_wdata; // see (R14)
    end
    // Hardware set wins over a clear in the same cycle
    if (set_verify) begin
      d.stat[`STAT_VERIFY_BIT] = 1'b1; // see (R08)
    end
    if (set_protect) begin
      d.stat[`STAT_PROTECT_BIT] = 1'b1; // see (R08)
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q        <= '0;
      q.st     <= S_IDLE;
      q.stat   <= `STAT_RESET;
    end else begin
      q <= d;
    end
  end

  assign cpu_halted       = q.busy;
  assign op_done          = q.done;
  assign flash_status_reg = q.stat; // see (R13)
  assign flash_addr       = {q.blk, q.lo};
  assign flash_wr_en      = q.wr_en;
  assign flash_wr_data    = q.data; // see (R11)
  assign wdt_restart      = q.wdt;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_launch;
    start ##1 cpu_halted;
  endsequence

  sequence s_resume;
    $fell(cpu_halted) && op_done;
  endsequence

  // Program strobe of PROG_CYCLES (10) cycles, split to keep counts small
  sequence s_prog_pulse;
    flash_wr_en [*5] ##1 flash_wr_en [*5] ##1 !flash_wr_en;
  endsequence

  property p_blank_start;
    (start && blank_cmd && blank_ok) |=> q.st == S_BLANK && !flash_wr_en;
  endproperty
  a_blank_start: assert property (p_blank_start) // see (R01)
    else $error("Blank check not started");

  property p_wdt;
    (wdt_wr && wdt_wdata == `WDT_RESTART_CODE) |=> wdt_restart ##1
      (wdt_restart == $past(wdt_wr && wdt_wdata == `WDT_RESTART_CODE));
  endproperty
  a_wdt: assert property (p_wdt) // see (R06)
    else $error("Watchdog restart wrong");

  property p_launch;
    (start && write_cmd && write_ok) |-> s_launch
      ##[1:300] s_resume;
  endproperty
  a_launch: assert property (p_launch) // see (R07)
    else $error("Halt launch or resume wrong");

  property p_blank_err;
    (q.st == S_BLANK && flash_rd_data != `BLANK_BYTE)
      |=> flash_status_reg[`STAT_VERIFY_BIT];
  endproperty
  a_blank_err: assert property (p_blank_err) // see (R08)
    else $error("Blank failure not flagged");

  property p_write_start;
    (start && write_cmd && write_ok) |=> s_prog_pulse;
  endproperty
  a_write_start: assert property (p_write_start) // see (R09)
    else $error("Byte program pulse wrong");

  property p_bad_start;
    (start && !(blank_cmd && blank_ok) && !(write_cmd && write_ok))
      |=> op_done && !cpu_halted && flash_status_reg[`STAT_PROTECT_BIT];
  endproperty
  a_bad_start: assert property (p_bad_start) // see (R08)
    else $error("Refused command not flagged");

  property p_write_data;
    (start && write_cmd && write_ok) |=>
      flash_wr_data == $past(write_data_buffer)
      && flash_addr == {$past(addr_pointer_high), $past(addr_pointer_low)};
  endproperty
  a_write_data: assert property (p_write_data) // see (R11)
    else $error("Programmed data differs");

  property p_done_status;
    (op_done && !$past(status_wr))
      |-> ((flash_status_reg[2:1] != 2'b00) || !q.err);
  endproperty
  a_done_status: assert property (p_done_status) // see (R13)
    else $error("Failure left status zero");

  property p_sticky;
    (flash_status_reg[`STAT_VERIFY_BIT] && !status_wr)
      |=> flash_status_reg[`STAT_VERIFY_BIT];
  endproperty
  a_sticky: assert property (p_sticky) // see (R14)
    else $error("Error bit lost without clear");

endmodule // flash_self_prog_blank_check_write

// File: tb/flash_self_prog_blank_check_write_test.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/100ps
`include "flash_seq_consts.svh"

module flash_self_prog_blank_check_write_test;
  logic        clk_sys = 0, reset_n = 0, mode = 1, halt = 0;
  logic        st_wr = 0, wdt_wr = 0, busy, done, wr_en, wdt_rst;
  logic [7:0]  cmd = 0, ph = 0, pl = 0, ch = 0, cl = 0, wbuf = 0;
  logic [7:0]  st_wd = 0, wdt_wd = 0, stat, wr_data, wd;
  logic [15:0] addr, n;
  logic [7:0]  mem [256];
  int          fails = 0, checked = 0;
  logic        seen_busy;

  always #50 clk_sys = ~clk_sys;

  // Cells can only lose bits when programmed, so a rewrite may fail verify
  assign wd = mem[addr[7:0]];
  always @(posedge clk_sys) if (wr_en) mem[addr[7:0]] <= wd & wr_data;

  flash_self_prog_blank_check_write dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .self_prog_mode(mode),
    .halt_exec(halt), .flash_command_reg(cmd), .addr_pointer_high(ph),
    .addr_pointer_low(pl), .addr_compare_high(ch), .addr_compare_low(cl),
    .write_data_buffer(wbuf), .status_wr(st_wr), .status_wdata(st_wd),
    .wdt_wr(wdt_wr), .wdt_wdata(wdt_wd), .flash_rd_data(wd),
    .cpu_halted(busy), .op_done(done), .flash_status_reg(stat),
    .flash_addr(addr), .flash_wr_en(wr_en), .flash_wr_data(wr_data),
    .wdt_restart(wdt_rst));

  task automatic chk(input string s, input logic [15:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Clears status, launches by a halt pulse, counts cycles to op_done
  task automatic op(input logic [7:0] c, h, l, hc, lc, d);
    @(negedge clk_sys);
    {cmd, ph, pl, ch, cl, wbuf} = {c, h, l, hc, lc, d};
    st_wr = 1;
    st_wd = 0;
    @(negedge clk_sys);
    st_wr = 0;
    halt = 1;
    @(negedge clk_sys);
    halt = 0;
    seen_busy = busy;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 400) begin
      fails++;
      final_report();
    end
    @(negedge clk_sys);
  endtask

  task automatic t_wdt;
    @(negedge clk_sys);
    wdt_wr = 1;
    wdt_wd = `WDT_RESTART_CODE;
    @(negedge clk_sys);
    wdt_wd = 8'h55;
    chk("wdt_restart", wdt_rst, 1);
    @(negedge clk_sys);
    wdt_wr = 0;
    chk("wdt_other", wdt_rst, 0);
  endtask

  task automatic t_blank;
    op(`CMD_BLANK_CHECK, 8'h07, 8'h00, 8'h07, 8'hff, 0);
    chk("blank_cycles", n, 16'h0100);
    chk("blank_ok", stat, 0);
    mem[8'h05] = 8'h00;
    op(`CMD_BLANK_CHECK, 8'h07, 8'h00, 8'h07, 8'hff, 0);
    repeat (3) @(negedge clk_sys);
    chk("blank_err", stat, 8'h01 << `STAT_VERIFY_BIT);
    st_wr = 1;
    @(negedge clk_sys);
    st_wr = 0;
    chk("clear", stat, 0);
  endtask

  task automatic t_write;
    op(`CMD_BYTE_WRITE, 8'h07, 8'h20, 0, 0, 8'h10);
    chk("wr_cycles", n, 16'(`PROG_CYCLES + 1));
    chk("wr_busy", seen_busy, 1);
    chk("done_pulse", done, 0);
    chk("wr_cell", mem[8'h20], 8'h10);
    chk("wr_addr", addr, 16'h0720);
    chk("wr_ok", stat, 0);
    op(`CMD_BYTE_WRITE, 8'h07, 8'h05, 0, 0, 8'h10);
    chk("wr_verify", stat, 8'h01 << `STAT_VERIFY_BIT);
  endtask

  task automatic t_protect;
    op(`CMD_BYTE_WRITE, 8'h08, 8'h20, 0, 0, 8'h10);
    chk("bad_block", stat, 8'h01 << `STAT_PROTECT_BIT);
    chk("bad_cycles", n, 0);
    chk("bad_busy", seen_busy, 0);
    op(`CMD_BLANK_CHECK, 8'h07, 8'h00, 8'h06, 8'hff, 0);
    chk("bad_cmp", stat, 8'h01 << `STAT_PROTECT_BIT);
    op(8'h03, 8'h07, 8'h00, 8'h07, 8'hff, 0);
    chk("bad_cmd", stat, 8'h01 << `STAT_PROTECT_BIT);
  endtask

  task automatic t_refuse;
    @(negedge clk_sys);
    mode = 0;
    halt = 1;
    @(negedge clk_sys);
    halt = 0;
    @(negedge clk_sys);
    chk("no_launch", {busy, done}, 0);
    mode = 1;
  endtask

  initial begin
    foreach (mem[i]) mem[i] = `BLANK_BYTE;
    repeat (2) @(negedge clk_sys);
    reset_n = 1;
    t_wdt();
    t_blank();
    t_write();
    t_protect();
    t_refuse();
    final_report();
  end
endmodule // flash_self_prog_blank_check_write_test
